// ---- verilog/pree_rise_enable.sv ----
// Rise-event enable register with set/clear aliases and rising-edge event generation
`timescale 1ns/1ps
`default_nettype none
`include "pree_map.svh"
module pree_rise_enable #(
  parameter int ID_SETTLE_CYCLES = `PREE_ID_SETTLE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [5:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       idGrounded,
  input  wire logic       sessionEnd,
  input  wire logic       sessionValid,
  input  wire logic       supplyValidLevel,
  input  wire logic       hostDisconnect,
  output logic      [4:0] riseEvent,
  output logic      [4:0] riseEnable,
  output logic      [7:0] otgCtrl
);
  logic [4:0] signalPrev;
  logic       idLive;
  logic       idPrimed;

  function automatic logic [7:0] pree_apply(input pree_pkg::pree_access_type acc,
                                            input logic [7:0] cur, input logic [7:0] wd);
    case (acc)
      pree_pkg::PREE_ACC_SET:   pree_apply = cur | wd;
      pree_pkg::PREE_ACC_CLEAR: pree_apply = cur & ~wd;
      default:                  pree_apply = wd;
    endcase
  endfunction

  // Aliases decode to an access kind on the one stored register
  wire hitRise = (regAddr == `PREE_ADDR_RISE_EN) || (regAddr == `PREE_ADDR_RISE_SET) ||
                 (regAddr == `PREE_ADDR_RISE_CLR);
  wire hitOtg  = (regAddr == `PREE_ADDR_OTG_CTRL) || (regAddr == `PREE_ADDR_OTG_SET) ||
                 (regAddr == `PREE_ADDR_OTG_CLR);
  wire pree_pkg::pree_access_type accKind =
    ((regAddr == `PREE_ADDR_RISE_SET) || (regAddr == `PREE_ADDR_OTG_SET)) ? pree_pkg::PREE_ACC_SET :
    ((regAddr == `PREE_ADDR_RISE_CLR) || (regAddr == `PREE_ADDR_OTG_CLR)) ? pree_pkg::PREE_ACC_CLEAR :
    pree_pkg::PREE_ACC_PLAIN;
  wire [7:0] riseWide = {3'h0, riseEnable};
  wire [7:0] next_riseWide = pree_apply(accKind, riseWide, regWdata);
  wire [7:0] next_otgCtrl  = pree_apply(accKind, otgCtrl, regWdata);
  wire [7:0] readMux = hitRise ? riseWide : (hitOtg ? otgCtrl : 8'h00);

  wire [4:0] signalNow = {idGrounded, sessionEnd, sessionValid, supplyValidLevel, hostDisconnect};
  wire [4:0] rising    = signalNow & ~signalPrev;
  wire       hostMode  = otgCtrl[`PREE_OTG_PLUS_PD] & otgCtrl[`PREE_OTG_MINUS_PD];
  // Primed flag holds id_grounded events off for one more cycle after idLive rises
  wire [4:0] allowed;
  assign allowed[`PREE_BIT_ID_GROUNDED]     = idLive & idPrimed;
  assign allowed[`PREE_BIT_SESSION_END]   = 1'b1;
  assign allowed[`PREE_BIT_SESSION_VALID] = 1'b1;
  assign allowed[`PREE_BIT_SUPPLY]    = 1'b1;
  assign allowed[`PREE_BIT_HOSTDISC]  = hostMode;

  pree_id_settle #(
    .SETTLE_CYCLES(ID_SETTLE_CYCLES)
  ) u_settle (
    .clk               (clk),
    .srst              (srst),
    .idLinePullSampling(otgCtrl[`PREE_OTG_ID_PULL]),
    .idLive            (idLive)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      riseEnable <= `PREE_RISE_EN_RESET;
      otgCtrl    <= `PREE_OTG_CTRL_RESET;
      regRdata   <= 8'h00;
      signalPrev <= 5'h00;
      riseEvent  <= 5'h00;
      idPrimed   <= 1'b0;
    end else begin
      if (regWrite && hitRise) riseEnable <= next_riseWide[4:0];
      if (regWrite && hitOtg) otgCtrl <= next_otgCtrl;
      regRdata   <= regRead ? readMux : 8'h00;
      signalPrev <= signalNow;
      idPrimed   <= idLive;
      riseEvent  <= rising & riseEnable & allowed;
    end
  end
endmodule
`default_nettype wire

// ---- include/pree_map.svh ----
// Register map, field positions, reset values and timing for the rise-event enable block
// Notes on behaviour
// - An enabled bit raises one event notification on each low-to-high change of its signal.
// - After reset all five rise-enable bits are one.
// - Bit 4 enables events on id_grounded rising.
// - id_grounded rising events are blocked while pull sampling is off and 50 ms after enabling.
// - Bit 3 enables events on session_end rising.
// - Bit 2 enables events on session_valid rising; same as a_device_session_ok.
// - Bit 1 enables events on supply_valid_level rising.
// - Bit 0 enables events on host-disconnect rising.
// - Host-disconnect events only count when both line pulldowns are one.
// - Writing the set alias 0x0E sets bits written one; reads return the enables.
// - The aliases hold no storage; 0x0E/0x0F act on the register at 0x0D, 0x0B/0x0C on 0x0A.
// - OTG control bit 0 is id_line_pull_sampling, reset zero.
// - OTG control bits 1 and 2 are plus/minus line pulldowns, reset one.
`ifndef PREE_MAP_SVH
`define PREE_MAP_SVH
`define PREE_ADDR_OTG_CTRL     6'h0A
`define PREE_ADDR_OTG_SET      6'h0B
`define PREE_ADDR_OTG_CLR      6'h0C
`define PREE_ADDR_RISE_EN      6'h0D
`define PREE_ADDR_RISE_SET     6'h0E
`define PREE_ADDR_RISE_CLR     6'h0F
`define PREE_BIT_HOSTDISC      0
`define PREE_BIT_SUPPLY        1
`define PREE_BIT_SESSION_VALID     2
`define PREE_BIT_SESSION_END       3
`define PREE_BIT_ID_GROUNDED         4
`define PREE_OTG_ID_PULL       0
`define PREE_OTG_PLUS_PD       1
`define PREE_OTG_MINUS_PD      2
`define PREE_RISE_EN_RESET     5'h1F
`define PREE_OTG_CTRL_RESET    8'h06
`define PREE_CLK_HZ            40000000
`define PREE_ID_SETTLE_MS      50
`define PREE_ID_SETTLE_CYCLES  ((`PREE_CLK_HZ / 1000) * `PREE_ID_SETTLE_MS)
`endif

// ---- include/pree_pkg.sv ----
// Types shared by the rise-event enable block
package pree_pkg;
  typedef enum logic [1:0] {
    PREE_ACC_PLAIN,
    PREE_ACC_SET,
    PREE_ACC_CLEAR
  } pree_access_type;
  typedef enum logic [1:0] {
    PREE_ID_OFF,
    PREE_ID_SETTLING,
    PREE_ID_LIVE
  } pree_id_state_type;
endpackage

// ---- verilog/pree_id_settle.sv ----
// Settling gate for id_grounded rise events after pull sampling is turned on
`timescale 1ns/1ps
`default_nettype none
`include "pree_map.svh"
module pree_id_settle #(
  parameter int SETTLE_CYCLES = `PREE_ID_SETTLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic idLinePullSampling,
  output logic      idLive
);
  pree_pkg::pree_id_state_type state;
  pree_pkg::pree_id_state_type next_state;
  logic [31:0]                 count;
  wire                         countDone = (count >= 32'(SETTLE_CYCLES - 1));

  always_comb begin
    next_state = state;
    case (state)
      pree_pkg::PREE_ID_OFF:
        if (idLinePullSampling) next_state = pree_pkg::PREE_ID_SETTLING;
      pree_pkg::PREE_ID_SETTLING:
        if (!idLinePullSampling) next_state = pree_pkg::PREE_ID_OFF;
        else if (countDone) next_state = pree_pkg::PREE_ID_LIVE;
      pree_pkg::PREE_ID_LIVE:
        if (!idLinePullSampling) next_state = pree_pkg::PREE_ID_OFF;
      default:
        next_state = pree_pkg::PREE_ID_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state  <= pree_pkg::PREE_ID_OFF;
      count  <= 32'h0;
      idLive <= 1'b0;
    end else begin
      state  <= next_state;
      count  <= (state == pree_pkg::PREE_ID_SETTLING) ? count + 32'h1 : 32'h0;
      idLive <= (next_state == pree_pkg::PREE_ID_LIVE);
    end
  end
endmodule
`default_nettype wire

// ---- dv/pree_rise_enable_sva.sv ----
// Port assertions for the rise-event enable block
`timescale 1ns/1ps
`default_nettype none
module pree_rise_enable_sva (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [5:0] regAddr,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       supplyValidLevel,
  input wire logic [4:0] riseEvent,
  input wire logic [4:0] riseEnable,
  input wire logic [7:0] otgCtrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rst; $fell(srst) |-> riseEnable == 5'h1F && otgCtrl == 8'h06; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_set; regWrite && regAddr == 6'h0E |=> riseEnable == ($past(riseEnable) | $past(regWdata[4:0])); endproperty
  a_set: assert property (p_set) else $error("set alias wrong");
  property p_clr; regWrite && regAddr == 6'h0F |=> riseEnable == ($past(riseEnable) & ~$past(regWdata[4:0])); endproperty
  a_clr: assert property (p_clr) else $error("clear alias wrong");
  property p_rd; regRead && regAddr inside {6'h0D, 6'h0E, 6'h0F} |=> regRdata == {3'h0, $past(riseEnable)}; endproperty
  a_rd: assert property (p_rd) else $error("enable readback wrong");
  property p_sv; $rose(supplyValidLevel) && riseEnable[1] |=> riseEvent[1]; endproperty
  a_sv: assert property (p_sv) else $error("supply rise event missing");
  property p_cause; riseEvent[1] |-> $past(riseEnable[1]) && $past(supplyValidLevel) && !$past(supplyValidLevel, 2); endproperty
  a_cause: assert property (p_cause) else $error("supply event without cause");
  property p_host; riseEvent[0] |-> &$past(otgCtrl[2:1]); endproperty
  a_host: assert property (p_host) else $error("disconnect event outside host mode");
  property p_id; riseEvent[4] |-> $past(otgCtrl[0], 20); endproperty
  a_id: assert property (p_id) else $error("id event while settling");
  c_id: cover property (riseEvent[4]);
  c_host: cover property (riseEvent[0]);
  c_rd: cover property (regRead && regAddr == 6'h0F);
endmodule
`default_nettype wire

// ---- dv/pree_link_model.sv ----
// Link-side register master for the rise-event enable block
`timescale 1ns/1ps
`default_nettype none
module pree_link_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdata,
  output logic      [5:0] regAddr = 6'h00,
  output logic            regWrite = 1'b0,
  output logic            regRead = 1'b0,
  output logic      [7:0] regWdata = 8'h00
);
  // Idle cycle after each strobe keeps one-cycle pulses apart
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    {regAddr, regWdata, regWrite, regRead} <= {a, d, w, !w};
    @(posedge clk);
    {regWrite, regRead} <= 2'b00;
    #1 q = regRdata;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- dv/pree_rise_enable_tb_top.sv ----
// Self-checking bench for the rise-event enable block
`timescale 1ns/1ps
`default_nettype none
module pree_rise_enable_tb_top;
  logic       clk = 1'b0, srst = 1'b1, regWrite, regRead;
  logic [4:0] sig = 5'h00, riseEvent, riseEnable, en;
  logic [5:0] regAddr, a;
  logic [7:0] regWdata, regRdata, otgCtrl, q, d;
  int         bad_count = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  pree_rise_enable #(.ID_SETTLE_CYCLES(20)) DUT (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .idGrounded(sig[4]), .sessionEnd(sig[3]),
    .sessionValid(sig[2]), .supplyValidLevel(sig[1]), .hostDisconnect(sig[0]), .riseEvent(riseEvent),
    .riseEnable(riseEnable), .otgCtrl(otgCtrl));
  pree_link_model LNK (.clk(clk), .regRdata(regRdata), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [4:0] nxt(input logic [5:0] ad, input logic [4:0] c, input logic [7:0] v);
    return ad == 6'h0D ? v[4:0] : ad == 6'h0E ? c | v[4:0] : c & ~v[4:0];
  endfunction
  task automatic rise(input int i, input logic e);
    sig[i] <= 1'b1;
    @(posedge clk);
    #1 chk("riseEvent", {7'h00, e}, {7'h00, riseEvent[i]});
    @(posedge clk);
    sig[i] <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    #1ms;
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(29755));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    LNK.acc(0, 6'h0D, 8'h00, q);
    chk("rise_event_enable", 8'h1F, q);
    chk("otgCtrl", 8'h06, otgCtrl);
    en = 5'h1F;
    for (int k = 0; k < 24; k++) begin
      a = 6'h0D + 6'($urandom_range(2));
      d = 8'($urandom);
      LNK.acc(1, a, d, q);
      en = nxt(a, en, d);
      LNK.acc(0, 6'h0D + 6'($urandom_range(2)), 8'h00, q);
      chk("rise_event_enable", {3'h0, en}, q);
      rise(k % 4, en[k % 4]);
    end
    LNK.acc(1, 6'h20, 8'hFF, q);
    LNK.acc(0, 6'h20, 8'h00, q);
    chk("unmapped", 8'h00, q);
    LNK.acc(1, 6'h0E, 8'h1F, q);
    rise(4, 1'b0);
    LNK.acc(1, 6'h0C, 8'h02, q);
    rise(0, 1'b0);
    LNK.acc(1, 6'h0B, 8'h01, q);
    rise(4, 1'b0);
    repeat (25) @(posedge clk);
    rise(4, 1'b1);
    LNK.acc(1, 6'h0F, 8'h1F, q);
    chk("riseEnable", 8'h00, {3'h0, riseEnable});
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk("riseEnable", 8'h1F, {3'h0, riseEnable});
    chk("otgCtrl", 8'h06, otgCtrl);
    stop_test();
  end
endmodule
bind pree_rise_enable pree_rise_enable_sva SVA (.clk(clk), .srst(srst), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .supplyValidLevel(supplyValidLevel),
  .riseEvent(riseEvent), .riseEnable(riseEnable), .otgCtrl(otgCtrl));
`default_nettype wire
